// ==== bench/test_temp_limit_fault_response.sv ====
// Self-checking testbench of the temperature limit and fault response block.
`default_nettype none
module test_temp_limit_fault_response
    import tlfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, clear_faults, clear_status, ctrl_pin, oper_on, rd_valid_q, rd_unsup_q, out_en_q, v, u;
    logic         unit_tick = 1'b0; // Delay time unit pulse.
    logic [1:0]   tick_cnt  = 2'h0; // One tick every four cycles.
    logic [15:0]  temp_meas, rd_data_q, d, w, ot, ut;
    tlfr_cmd_t    cmd;
    tlfr_status_t status_q;
    int           miscompares = 0, num_checks = 0;
    logic [7:0]   codes [4] = '{TLFR_CMD_OT_WARN, TLFR_CMD_UT_WARN, TLFR_CMD_UT_FAULT, TLFR_CMD_UT_RESP};

    tlfr_top uut (.clock(clock), .rst_n(rst_n), .cmd(cmd), .clear_faults(clear_faults),
        .clear_status(clear_status), .ctrl_pin(ctrl_pin), .oper_on(oper_on), .temp_meas(temp_meas),
        .unit_tick(unit_tick), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .rd_unsup_q(rd_unsup_q),
        .out_en_q(out_en_q), .status_q(status_q));
    tlfr_host host (.clock(clock), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
        .rd_unsup_q(rd_unsup_q), .cmd(cmd));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Time unit source, kept short so delays stay a few dozen cycles.
    always @(negedge clock) begin
        tick_cnt <= tick_cnt + 2'h1;
        unit_tick <= (tick_cnt == 2'h3);
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Bounded wait on the output enable; running out ends the run.
    task automatic wait_en(input logic val, input int bound);
        for (int i = 0; i < bound && out_en_q !== val; i++) @(negedge clock);
        check("out_en_q", {15'h0000, out_en_q}, {15'h0000, val});
        if (out_en_q !== val) end_of_test();
    endtask
    task automatic rdc(input logic [7:0] code, input logic [15:0] exp);
        host.rd(code, d, v, u);
        check("rd_valid_q", {15'h0000, v}, 16'h0001);
        check("rd_data_q", d, exp);
    endtask
    // Limits use exponent zero, so the mantissa alone orders them.
    function automatic logic lt(input logic [15:0] a, input logic [15:0] b);
        return $signed(a[10:0]) < $signed(b[10:0]);
    endfunction
    // Program a fault action with the output commanded off, so a new retry
    // setting never meets an attempt count left over from a running retry.
    task automatic arm(input logic [7:0] act);
        oper_on = 1'b0;
        temp_meas = 16'h00C8;
        host.send(1'b1, TLFR_CMD_UT_FAULT, 16'h0064);
        host.send(1'b1, TLFR_CMD_UT_RESP, {8'h00, act});
        oper_on = 1'b1;
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        wait_en(1'b1, 20);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h87FA8B59));
        {rst_n, clear_faults, clear_status} = 3'h0;
        {ctrl_pin, oper_on} = 2'h3;
        temp_meas = 16'h00C8;
        cyc(5);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) rdc(codes[i], 16'h0000);
        host.rd(8'hD2, d, v, u);
        check("rd_unsup_q", {14'h0000, v, u}, 16'h0001);
        // Top of the range, so no random limit or action can start a fault response.
        temp_meas = 16'h7BFF;
        for (int i = 0; i < 16; i++) begin
            w = 16'($urandom);
            host.send(1'b1, codes[i % 4], w);
            rdc(codes[i % 4], (i % 4 == 3) ? {8'h00, w[7:0]} : w);
        end
        for (int i = 0; i < 8; i++) begin
            ot = {5'h00, 11'($urandom)};
            ut = {5'h00, 11'($urandom)};
            temp_meas = {5'h00, 11'($urandom)};
            host.send(1'b1, TLFR_CMD_OT_WARN, ot);
            host.send(1'b1, TLFR_CMD_UT_WARN, ut);
            cyc(3);
            check("ot_warn", {15'h0000, status_q.ot_warn}, {15'h0000, lt(ot, temp_meas)});
            check("ut_warn", {15'h0000, status_q.ut_warn}, {15'h0000, lt(temp_meas, ut)});
        end
        arm(8'h00);
        temp_meas = 16'h0000;
        cyc(20);
        check("ignore out_en_q", {15'h0000, out_en_q}, 16'h0001);
        check("ut_fault", {15'h0000, status_q.ut_fault}, 16'h0001);
        arm({2'h1, 3'h0, 3'h2});
        temp_meas = 16'h0000;
        cyc(8);
        check("run on out_en_q", {15'h0000, out_en_q}, 16'h0001);
        wait_en(1'b0, 24);
        temp_meas = 16'h00C8;
        cyc(20);
        check("no retry out_en_q", {15'h0000, out_en_q}, 16'h0000);
        clear_status = 1'b1;
        cyc(1);
        clear_status = 1'b0;
        wait_en(1'b1, 10);
        arm({2'h2, 3'h0, 3'h0});
        temp_meas = 16'h0000;
        wait_en(1'b0, 4);
        temp_meas = 16'h00C8;
        cyc(20);
        check("no retry disable out_en_q", {15'h0000, out_en_q}, 16'h0000);
        arm({2'h2, 3'h1, 3'h1});
        temp_meas = 16'h0000;
        wait_en(1'b0, 4);
        cyc(20);
        temp_meas = 16'h00C8;
        cyc(20);
        check("retry once out_en_q", {15'h0000, out_en_q}, 16'h0000);
        oper_on = 1'b0;
        cyc(3);
        oper_on = 1'b1;
        wait_en(1'b1, 10);
        check("on edge ut_fault", {15'h0000, status_q.ut_fault}, 16'h0000);
        arm({2'h2, 3'h7, 3'h0});
        temp_meas = 16'h0000;
        wait_en(1'b0, 4);
        cyc(60);
        temp_meas = 16'h00C8;
        wait_en(1'b1, 12);
        arm({2'h3, 3'h7, 3'h0});
        temp_meas = 16'h0000;
        wait_en(1'b0, 4);
        temp_meas = 16'h00C8;
        cyc(20);
        check("latched out_en_q", {15'h0000, out_en_q}, 16'h0000);
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        wait_en(1'b1, 10);
        temp_meas = 16'h0000;
        wait_en(1'b0, 4);
        temp_meas = 16'h00C8;
        ctrl_pin = 1'b0;
        cyc(5);
        ctrl_pin = 1'b1;
        wait_en(1'b1, 10);
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== bench/tlfr_host.sv ====
// Host model that issues register commands to the limit block.
`default_nettype none
module tlfr_host
    import tlfr_pkg::*;
(
    input  wire logic        clock,      // System clock.
    input  wire logic        rd_valid_q, // Read answer valid.
    input  wire logic [15:0] rd_data_q,  // Read answer data.
    input  wire logic        rd_unsup_q, // Unmapped code flag.
    output var  tlfr_cmd_t   cmd         // Command towards the block.
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cmd = '0;

    // One command for one cycle; afterwards the fields show the inverse
    // value so that nothing can lean on stale code or data.
    task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
        @(negedge clock);
        cmd = '{1'b1, wr, code, data};
        @(negedge clock);
        cmd = '{1'b0, 1'b0, ~code, ~data};
    endtask

    // Read: the answer pulse is looked at in the cycle that it stands.
    task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic vld, output logic uns);
        send(1'b0, code, 16'h0000);
        data = rd_data_q;
        vld = rd_valid_q;
        uns = rd_unsup_q;
    endtask
endmodule
`default_nettype wire

// ==== hw/tlfr_pkg.sv ====
// Package of constants and types for the temperature limit and fault response block.
`default_nettype none
package tlfr_pkg;
    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] TLFR_CMD_OT_WARN  = 8'h51; // Over-temperature warning limit.
    localparam logic [7:0] TLFR_CMD_UT_WARN  = 8'h52; // Under-temperature warning limit.
    localparam logic [7:0] TLFR_CMD_UT_FAULT = 8'h53; // Under-temperature fault limit.
    localparam logic [7:0] TLFR_CMD_UT_RESP  = 8'h54; // Under-temperature fault action.

    // ------------------------------------------------------------------
    // Reset values of the limit and action registers
    // ------------------------------------------------------------------
    localparam logic [15:0] TLFR_RST_OT_WARN  = 16'h0000; // Warning limit after reset.
    localparam logic [15:0] TLFR_RST_UT_WARN  = 16'h0000; // Warning limit after reset.
    localparam logic [15:0] TLFR_RST_UT_FAULT = 16'h0000; // Fault limit after reset.
    localparam logic [7:0]  TLFR_RST_UT_RESP  = 8'h00;    // Action byte after reset.

    // ------------------------------------------------------------------
    // Field layout of the action byte
    // ------------------------------------------------------------------
    localparam int TLFR_RESP_HI  = 7; // Response field, top bit.
    localparam int TLFR_RESP_LO  = 6; // Response field, bottom bit.
    localparam int TLFR_RETRY_HI = 5; // Retry field, top bit.
    localparam int TLFR_RETRY_LO = 3; // Retry field, bottom bit.
    localparam int TLFR_DELAY_HI = 2; // Delay field, top bit.
    localparam int TLFR_DELAY_LO = 0; // Delay field, bottom bit.

    // Retry codes with a meaning of their own.
    localparam logic [2:0] TLFR_RETRY_NONE    = 3'h0; // No restart attempt.
    localparam logic [2:0] TLFR_RETRY_ENDLESS = 3'h7; // Retry without limit.

    // Linear number format: five-bit exponent over an eleven-bit mantissa.
    localparam int TLFR_EXP_HI  = 15; // Exponent, top bit.
    localparam int TLFR_EXP_LO  = 11; // Exponent, bottom bit.
    localparam int TLFR_MANT_HI = 10; // Mantissa, top bit.
    localparam int TLFR_FRAC    = 16; // Fraction bits of the fixed-point compare value.

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TLFR_ACT_IGNORE  = 2'h0, // Keep regulating.
        TLFR_ACT_DELAY   = 2'h1, // Run on for the delay, then retry handling.
        TLFR_ACT_DISABLE = 2'h2, // Disable at once, then retry handling.
        TLFR_ACT_LATCH   = 2'h3  // Disable until the fault is cleared.
    } tlfr_action_t;

    typedef struct packed {
        logic        valid; // Command present this cycle.
        logic        write; // High for a write, low for a read.
        logic [7:0]  code;  // Command code.
        logic [15:0] wdata; // Write data, byte commands use the low byte.
    } tlfr_cmd_t;

    typedef struct packed {
        logic ot_warn;  // Temperature above the over-temperature warning limit.
        logic ut_warn;  // Temperature below the under-temperature warning limit.
        logic ut_fault; // Latched under-temperature fault status.
    } tlfr_status_t;
endpackage
`default_nettype wire

// ==== hw/tlfr_top.sv ====
// Temperature limit registers and under-temperature fault response logic.
//
// Summary of operation
// - Response 00 keeps regulating through the fault.
// - Response 01 runs on for delay, then retries.
// - Response 10 disables at once, then retries.
// - Response 11 holds output off until cleared.
// - Commanding output off then on clears faults.
// - Retry 000 never restarts; stays off.
// - Retry 001 makes one attempt, then latches.
// - Attempts spaced by delay count times unit.
// - Over-temperature warning limit at code 51h.
// - Under-temperature warning limit at code 52h.
// - Under-temperature fault limit at code 53h.
// - Delay field n selects two to the n units.
// - Retry 2..6 attempts; 111 retries without limit.
`default_nettype none
module tlfr_top
    import tlfr_pkg::*;
(
    input  wire logic         clock,       // 200 MHz system clock.
    input  wire logic         rst_n,       // Asynchronous reset, active low.
    input  wire tlfr_cmd_t    cmd,         // Command from the serial bus front end.
    input  wire logic         clear_faults,// Clear-faults command pulse.
    input  wire logic         clear_status,// Pulse that clears the fault status bit and releases a latched fault.
    input  wire logic         ctrl_pin,    // Control pin, asynchronous level.
    input  wire logic         oper_on,     // On bit of the operation command.
    input  wire logic [15:0]  temp_meas,   // Measured temperature, linear format.
    input  wire logic         unit_tick,   // One-cycle pulse per delay time unit.
    output logic              rd_valid_q,  // Read answer valid, one cycle.
    output logic [15:0]       rd_data_q,   // Read answer data.
    output logic              rd_unsup_q,  // Command code not served here.
    output logic              out_en_q,    // Converter output enable.
    output tlfr_status_t      status_q     // Warning and fault flags.
);
    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Turns a linear value into signed fixed point so limits compare exactly.
    function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
        logic signed [47:0] m;
        logic signed [5:0]  e;
        m = 48'(signed'(v[TLFR_MANT_HI:0]));
        e = 6'(signed'(v[TLFR_EXP_HI:TLFR_EXP_LO]));
        lin_fix = m <<< (6'(TLFR_FRAC) + e);
    endfunction

    // Delay field n gives two to the n time units.
    function automatic logic [7:0] delay_units(input logic [2:0] n);
        delay_units = 8'h01 << n;
    endfunction

    // ------------------------------------------------------------------
    // Registers and pin synchroniser
    // ------------------------------------------------------------------
    logic [15:0]  ot_warn_lim_q;   // Over-temperature warning limit.
    logic [15:0]  ut_warn_lim_q;   // Under-temperature warning limit.
    logic [15:0]  ut_fault_lim_q;  // Under-temperature fault limit.
    logic [7:0]   ut_action_q;     // Under-temperature fault action byte.
    logic         ctrl_s1_q;       // First synchroniser stage of the control pin.
    logic         ctrl_s2_q;       // Second synchroniser stage of the control pin.
    logic         run_req_q;       // Run request one cycle ago, for the on edge.
    logic [7:0]   tmr_q;           // Time units counted in the current delay.
    logic [2:0]   attempts_q;      // Failed restart attempts so far.

    typedef enum logic [1:0] {TLFR_ST_RUN, TLFR_ST_DELAY, TLFR_ST_WAIT, TLFR_ST_LATCH} tlfr_state_t;
    tlfr_state_t  state_q;         // Fault response state.
    tlfr_state_t  state_d;         // Next fault response state.
    logic         tmr_clr;         // Restart the delay timer.
    logic [2:0]   attempts_d;      // Next attempt count.

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire          wr_en     = cmd.valid & cmd.write;
    wire          rd_en     = cmd.valid & ~cmd.write;
    wire          hit_ot    = cmd.code == TLFR_CMD_OT_WARN;
    wire          hit_utw   = cmd.code == TLFR_CMD_UT_WARN;
    wire          hit_utf   = cmd.code == TLFR_CMD_UT_FAULT;
    wire          hit_resp  = cmd.code == TLFR_CMD_UT_RESP;
    wire          hit_any   = hit_ot | hit_utw | hit_utf | hit_resp;
    wire tlfr_action_t action = tlfr_action_t'(ut_action_q[TLFR_RESP_HI:TLFR_RESP_LO]);
    wire    [2:0] retry     = ut_action_q[TLFR_RETRY_HI:TLFR_RETRY_LO];
    wire    [2:0] delay_n   = ut_action_q[TLFR_DELAY_HI:TLFR_DELAY_LO];
    wire    [7:0] units     = delay_units(delay_n);
    wire signed [47:0] temp_fix = lin_fix(temp_meas);
    wire          ot_warn_now  = temp_fix > lin_fix(ot_warn_lim_q);
    wire          ut_warn_now  = temp_fix < lin_fix(ut_warn_lim_q);
    wire          ut_fault_now = temp_fix < lin_fix(ut_fault_lim_q);
    // The output is wanted only while both the pin and the on bit ask for it.
    wire          run_req   = ctrl_s2_q & oper_on;
    wire          turn_on   = run_req & ~run_req_q;
    wire          clear_all = clear_faults | clear_status | turn_on;
    wire          timer_done = unit_tick & ((tmr_q + 8'h01) == units);
    // Attempt count after the attempt now failing.
    wire    [2:0] attempts_inc = attempts_q + 3'h1;
    wire          retry_spent = (retry != TLFR_RETRY_ENDLESS) && (attempts_inc >= retry);
    wire          read_sel  = rd_en & hit_any;
    wire   [15:0] read_mux  = hit_ot  ? ot_warn_lim_q  :
                              hit_utw ? ut_warn_lim_q  :
                              hit_utf ? ut_fault_lim_q :
                              hit_resp ? {8'h00, ut_action_q} : 16'h0000;

    // ------------------------------------------------------------------
    // Control pin synchroniser
    // ------------------------------------------------------------------
    // The pin is asynchronous, so only the second stage feeds logic.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_s1_q <= 1'b0;
            ctrl_s2_q <= 1'b0;
        end else begin
            ctrl_s1_q <= ctrl_pin;
            ctrl_s2_q <= ctrl_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Limit and action registers
    // ------------------------------------------------------------------
    // Writes land one edge after the command is presented.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ot_warn_lim_q  <= TLFR_RST_OT_WARN;
            ut_warn_lim_q  <= TLFR_RST_UT_WARN;
            ut_fault_lim_q <= TLFR_RST_UT_FAULT;
            ut_action_q    <= TLFR_RST_UT_RESP;
        end else if (wr_en) begin
            if (hit_ot)   ot_warn_lim_q  <= cmd.wdata;
            if (hit_utw)  ut_warn_lim_q  <= cmd.wdata;
            if (hit_utf)  ut_fault_lim_q <= cmd.wdata;
            if (hit_resp) ut_action_q    <= cmd.wdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------------
    // Unknown codes answer zero and raise the unsupported flag.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= 16'h0000;
            rd_unsup_q <= 1'b0;
        end else begin
            rd_valid_q <= read_sel;
            rd_data_q  <= read_sel ? read_mux : 16'h0000;
            rd_unsup_q <= cmd.valid & ~hit_any;
        end
    end

    // ------------------------------------------------------------------
    // Fault response state machine
    // ------------------------------------------------------------------
    // A command off overrides every state, which also ends endless retries.
    always_comb begin
        state_d    = state_q;
        tmr_clr    = 1'b0;
        attempts_d = attempts_q;
        if (!run_req) begin
            state_d    = TLFR_ST_RUN;
            attempts_d = 3'h0;
        end else begin
            case (state_q)
                TLFR_ST_RUN: begin
                    attempts_d = 3'h0;
                    tmr_clr    = 1'b1;
                    if (ut_fault_now) begin
                        case (action)
                            TLFR_ACT_IGNORE:  state_d = TLFR_ST_RUN;
                            TLFR_ACT_DELAY:   state_d = TLFR_ST_DELAY;
                            TLFR_ACT_DISABLE: state_d = (retry == TLFR_RETRY_NONE) ? TLFR_ST_LATCH : TLFR_ST_WAIT;
                            default:          state_d = TLFR_ST_LATCH;
                        endcase
                    end
                end
                TLFR_ST_DELAY: begin
                    // at delay end check the fault again
                    if (timer_done) begin
                        tmr_clr = 1'b1;
                        if (!ut_fault_now) begin
                            state_d = TLFR_ST_RUN;
                        end else begin
                            state_d = (retry == TLFR_RETRY_NONE) ? TLFR_ST_LATCH : TLFR_ST_WAIT;
                        end
                    end
                end
                TLFR_ST_WAIT: begin
                    if (timer_done) begin
                        tmr_clr = 1'b1;
                        if (!ut_fault_now) begin
                            state_d    = TLFR_ST_RUN;
                            attempts_d = 3'h0;
                        end else begin
                            // failed attempts latch once the budget is spent
                            attempts_d = attempts_inc;
                            state_d    = retry_spent ? TLFR_ST_LATCH : TLFR_ST_WAIT;
                        end
                    end
                end
                TLFR_ST_LATCH: begin
                    // only a clear lets the output return
                    if (clear_all) begin
                        state_d = TLFR_ST_RUN;
                    end
                end
                default: state_d = TLFR_ST_RUN;
            endcase
        end
    end

    // State, timer and attempt registers.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= TLFR_ST_RUN;
            tmr_q      <= 8'h00;
            attempts_q <= 3'h0;
            run_req_q  <= 1'b0;
        end else begin
            state_q    <= state_d;
            attempts_q <= attempts_d;
            run_req_q  <= run_req;
            tmr_q      <= tmr_clr ? 8'h00 : (unit_tick ? tmr_q + 8'h01 : tmr_q);
        end
    end

    // ------------------------------------------------------------------
    // Output enable and status flags
    // ------------------------------------------------------------------
    // The output runs in RUN and DELAY only; a restart is the return to RUN.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_en_q <= 1'b0;
            status_q <= '0;
        end else begin
            out_en_q         <= run_req && (state_d == TLFR_ST_RUN || state_d == TLFR_ST_DELAY);
            status_q.ot_warn <= ot_warn_now;
            status_q.ut_warn <= ut_warn_now;
            // sticky fault, a new fault beats a clear
            status_q.ut_fault <= ut_fault_now | (status_q.ut_fault & ~clear_all);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_ignore_runs;
        @(posedge clock) disable iff (!rst_n)
        (state_q == TLFR_ST_RUN && action == TLFR_ACT_IGNORE && run_req) |=> out_en_q;
    endproperty
    a_ignore_runs: assert property (p_ignore_runs) else $error("Ignore response dropped the output.");

    property p_delay_keeps_on;
        @(posedge clock) disable iff (!rst_n)
        (state_q == TLFR_ST_RUN && ut_fault_now && action == TLFR_ACT_DELAY && run_req)
            |=> (state_q == TLFR_ST_DELAY && out_en_q);
    endproperty
    a_delay_keeps_on: assert property (p_delay_keeps_on) else $error("Delay response did not run on.");

    property p_disable_now;
        @(posedge clock) disable iff (!rst_n)
        (state_q == TLFR_ST_RUN && ut_fault_now && action == TLFR_ACT_DISABLE) |=> !out_en_q;
    endproperty
    a_disable_now: assert property (p_disable_now) else $error("Disable response left the output on.");

    property p_latch_holds;
        @(posedge clock) disable iff (!rst_n)
        (state_q == TLFR_ST_LATCH && !clear_all && run_req) |=> (state_q == TLFR_ST_LATCH && !out_en_q);
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("Latched fault released without a clear.");

    property p_on_edge_clears;
        @(posedge clock) disable iff (!rst_n)
        (turn_on && !ut_fault_now) |=> !status_q.ut_fault;
    endproperty
    a_on_edge_clears: assert property (p_on_edge_clears) else $error("Off then on did not clear the fault.");

    property p_no_retry;
        @(posedge clock) disable iff (!rst_n)
        (state_q == TLFR_ST_RUN && ut_fault_now && action == TLFR_ACT_DISABLE
            && retry == TLFR_RETRY_NONE && run_req) |=> (state_q == TLFR_ST_LATCH);
    endproperty
    a_no_retry: assert property (p_no_retry) else $error("Retry setting zero did not latch.");

    property p_one_retry;
        @(posedge clock) disable iff (!rst_n)
        (state_q == TLFR_ST_WAIT && retry == 3'h1 && timer_done && ut_fault_now && run_req)
            |=> (state_q == TLFR_ST_LATCH);
    endproperty
    a_one_retry: assert property (p_one_retry) else $error("Single retry did not latch on failure.");

    property p_interval;
        @(posedge clock) disable iff (!rst_n)
        (state_q == TLFR_ST_WAIT && unit_tick && (tmr_q + 8'h01) < units && run_req)
            |=> (state_q == TLFR_ST_WAIT && tmr_q == $past(tmr_q) + 8'h01);
    endproperty
    a_interval: assert property (p_interval) else $error("Restart came before the interval ended.");

    property p_retry_budget;
        @(posedge clock) disable iff (!rst_n)
        (state_q == TLFR_ST_WAIT && retry != TLFR_RETRY_ENDLESS) |-> (attempts_q < retry);
    endproperty
    a_retry_budget: assert property (p_retry_budget) else $error("More attempts than the retry setting.");

    property p_ot_limit_write;
        @(posedge clock) disable iff (!rst_n)
        (wr_en && hit_ot) |=> (ot_warn_lim_q == $past(cmd.wdata));
    endproperty
    a_ot_limit_write: assert property (p_ot_limit_write) else $error("Warning limit write lost.");

    property p_fault_flag;
        @(posedge clock) disable iff (!rst_n)
        ut_fault_now |=> status_q.ut_fault;
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("Fault flag missed a fault.");
endmodule
`default_nettype wire
